// ===== rtl/rsf_pkg.sv
/*
 * rsf_pkg: constants, field layouts and types of the regulator fault
 * supervisor. Assumes a 10 MHz core clock and a 32-bit Avalon-MM bus.
 */
// Functional notes
// RQ1: timer codes 0..10 give 1 ms doubling to 1024 ms; code 11 gives 2056 ms.
// RQ2: codes 12..14 are reserved for the host; code 15 turns the timer off.
// RQ3: each rail has ignore bits for current limit, overvoltage, undervoltage.
// RQ4: ignore bits load their start value from one-time-programmed inputs.
// RQ5: ignored faults skip counter, timer, rail shutdown and power-good drop.
// RQ6: ignored faults still set their latch and may drive the interrupt.
// RQ7: gate select 0 frees reset; OV/UV arm after release and blanking.
// RQ8: gate select 1 releases host reset only when rails are in regulation.
// RQ9: OV/UV stay masked until reset is ready; then enabled rails are checked.
// RQ10: a bad rail holds reset and pauses the sequence for up to 2 ms.
// RQ11: still out of regulation after 2 ms aborts and turns off enabled rails.
// RQ12: rails enabled after release are monitored and enter fault protection.
// RQ13: faults after release never stop the rest of the power-up sequence.
// RQ14: in GPIO mode the power-good pin is free; reset needs one rail first.
// RQ15: latches set on their event, read anytime, clear on a written 1.
// RQ16: mask 1 keeps a latch off the interrupt pin; mask 0 lets it pull low.
// RQ17: sense bits show the live unlatched fault signals.
// RQ18: the interrupt pin is low when any unmasked latch is set.
// RQ19: in power-good mode the pin shows OV/UV failure at the reset point.
// RQ20: a fault runs the window timer; clear resets it, expiry powers down.
// RQ21: each fault bumps the 4-bit counter until the limit; limit 0 disables.
// RQ22: keep-on bit 0 turns the rail off on that fault, 1 keeps it running.
// RQ23: writing 0 to a latch bit leaves that latch unchanged.
package rsf_pkg;
	localparam int N_RAIL = 4;
	localparam int N_FLT  = 3 * N_RAIL;

	// *************************************************************
	// timing
	// *************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_TIME_US    = 1000;
	localparam int HOLD_TIME_US  = 2000;
	localparam int BLANK_TIME_US = 10;
	localparam int MS_CYC    = MS_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int HOLD_CYC  = HOLD_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int BLANK_CYC = BLANK_TIME_US * 1000 / CLK_PERIOD_NS;

	// *************************************************************
	// fault window codes
	// *************************************************************
	localparam logic [3:0]  TMR_LAST_POW = 4'hA;
	localparam logic [3:0]  TMR_CODE_LONG = 4'hB;
	localparam logic [3:0]  TMR_CODE_OFF  = 4'hF;
	localparam logic [11:0] TMR_LONG_MS   = 12'h808;
	localparam logic [11:0] TMR_BASE_MS   = 12'h001;

	// *************************************************************
	// register map (byte addresses)
	// *************************************************************
	localparam logic [4:0] A_CTRL   = 5'h00;
	localparam logic [4:0] A_IGNORE = 5'h04;
	localparam logic [4:0] A_KEEP   = 5'h08;
	localparam logic [4:0] A_LATCH  = 5'h0C;
	localparam logic [4:0] A_MASK   = 5'h10;
	localparam logic [4:0] A_SENSE  = 5'h14;
	localparam logic [4:0] A_STATUS = 5'h18;

	localparam int F_TMR_LO   = 0;
	localparam int F_LIM_LO   = 4;
	localparam int F_PGVAL    = 8;
	localparam int F_CNT_LO   = 0;
	localparam int F_ST_TMR   = 4;
	localparam int F_ST_HOLD  = 5;
	localparam int F_ST_ABORT = 6;
	localparam int F_ST_REL   = 7;
	localparam int F_ST_PDN   = 8;

	localparam logic [N_FLT-1:0] KEEP_RST = 12'h000;
	localparam logic [N_FLT-1:0] MASK_RST = 12'h000;

	typedef enum logic [4:0] {
		ST_WAIT  = 5'h01,
		ST_CHECK = 5'h02,
		ST_HOLD  = 5'h04,
		ST_RUN   = 5'h08,
		ST_ABORT = 5'h10
	} rsf_state_t;

	// fault vectors are ordered current limit, overvoltage, undervoltage
	typedef struct packed {
		logic [N_RAIL-1:0] uv;
		logic [N_RAIL-1:0] ov;
		logic [N_RAIL-1:0] ilim;
	} rsf_flt_t;

	typedef struct packed {
		logic [4:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} rsf_avs_req_t;
endpackage : rsf_pkg

// ===== rtl/rsf_supervisor.sv
/*
 * rsf_supervisor: fault window timer, per-rail ignore and keep-on
 * controls, power-up reset gating with a 2 ms recovery window, and the
 * latch/mask/sense interrupt set, all behind an Avalon-MM slave.
 * Assumes fault and regulation inputs are synchronous to i_clk and that
 * the power-up sequencer reports enabled rails and the reset slot.
 */
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rsf_supervisor import rsf_pkg::*; #(
	parameter int MS_CYCLES    = MS_CYC,
	parameter int HOLD_CYCLES  = HOLD_CYC,
	parameter int BLANK_CYCLES = BLANK_CYC
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire rsf_avs_req_t      i_avs,
	output logic [31:0]            o_avs_readdata,
	output logic                   o_avs_waitrequest,
	input  wire rsf_flt_t          i_fault_raw,
	input  wire logic [N_RAIL-1:0] i_internal_regulation_ok,
	input  wire logic [N_RAIL-1:0] i_rail_enabled,
	input  wire logic              i_reset_slot_ready,
	input  wire rsf_flt_t          i_otp_ignore,
	input  wire logic [3:0]        i_otp_timer_fault,
	input  wire logic [3:0]        i_otp_fault_count_limit,
	input  wire logic              i_otp_regulation_gate_sel,
	input  wire logic              i_otp_pg_mode,
	output logic                   o_host_reset_out_n,
	output logic                   o_irq_n_out,
	output logic                   o_power_good_pin,
	output logic [N_RAIL-1:0]      o_rail_off,
	output logic                   o_seq_pause,
	output logic                   o_powerdown_req
);
	// *************************************************************
	// elaboration checks
	// *************************************************************
	if (MS_CYCLES < 1 || MS_CYCLES > 16383)
		$error("MS_CYCLES out of range");
	if (HOLD_CYCLES < 1 || HOLD_CYCLES > 32767)
		$error("HOLD_CYCLES out of range");
	if (BLANK_CYCLES < 1 || BLANK_CYCLES > 16383)
		$error("BLANK_CYCLES out of range");

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	function automatic logic [11:0] window_ms(input logic [3:0] code);
		if (code <= TMR_LAST_POW)
			window_ms = TMR_BASE_MS << code;
		else if (code == TMR_CODE_LONG)
			window_ms = TMR_LONG_MS;
		else
			window_ms = 12'h000;
	endfunction : window_ms

	// *************************************************************
	// registers
	// *************************************************************
	rsf_state_t        state_reg, state_next;
	logic [3:0]        tmr_code_reg, lim_reg, cnt_reg;
	logic              pgval_reg;
	logic [N_FLT-1:0]  ign_reg, keep_reg, latch_reg, mask_reg;
	logic [N_FLT-1:0]  armed_prev_reg, eff_prev_reg;
	logic              ack_reg, wait_reg;
	logic [31:0]       rdata_reg;
	logic              rel_reg, blank_done_reg, pdn_reg;
	logic [13:0]       blank_cnt_reg, ms_pre_reg;
	logic [11:0]       ms_cnt_reg;
	logic [14:0]       hold_cnt_reg;
	logic              irq_n_reg, pg_reg, rst_n_reg, pause_reg;
	logic [N_RAIL-1:0] off_reg;

	// *************************************************************
	// bus decode: one wait cycle, answer in the second
	// *************************************************************
	wire        req       = i_avs.read | i_avs.write;
	wire        ack_next  = req & ~ack_reg;
	wire        wr_ok     = ack_reg & i_avs.write;
	wire [31:0] bm        = be_mask(i_avs.byteenable);
	wire [31:0] wd        = i_avs.writedata & bm;
	wire        wr_ctrl   = wr_ok & (i_avs.address == A_CTRL);
	wire        wr_ign    = wr_ok & (i_avs.address == A_IGNORE);
	wire        wr_keep   = wr_ok & (i_avs.address == A_KEEP);
	wire        wr_latch  = wr_ok & (i_avs.address == A_LATCH);
	wire        wr_mask   = wr_ok & (i_avs.address == A_MASK);
	wire        wr_status = wr_ok & (i_avs.address == A_STATUS);
	wire [31:0] ctrl_word = {23'h0, pgval_reg, lim_reg, tmr_code_reg};
	wire [31:0] ctrl_new  = (ctrl_word & ~bm) | wd;
	wire [N_FLT-1:0] bm12 = bm[N_FLT-1:0];
	wire [N_FLT-1:0] ign_new  = (ign_reg & ~bm12) | wd[N_FLT-1:0];
	wire [N_FLT-1:0] keep_new = (keep_reg & ~bm12) | wd[N_FLT-1:0];
	wire [N_FLT-1:0] mask_new = (mask_reg & ~bm12) | wd[N_FLT-1:0];
	wire [N_FLT-1:0] clr = wr_latch ? wd[N_FLT-1:0] : '0; // RQ23

	// *************************************************************
	// fault qualification
	// *************************************************************
	wire [N_FLT-1:0] raw   = i_fault_raw;
	wire [N_RAIL-1:0] en   = i_rail_enabled;
	wire ovuv_arm = rel_reg & blank_done_reg; // RQ7 RQ9
	wire [N_FLT-1:0] armed = raw & {{2{en & {N_RAIL{ovuv_arm}}}}, en}; // RQ12
	wire [N_FLT-1:0] eff   = armed & ~ign_reg; // RQ5
	wire [N_FLT-1:0] ev    = armed & ~armed_prev_reg;
	wire [N_FLT-1:0] eff_ev = eff & ~eff_prev_reg;
	wire [N_FLT-1:0] latch_next = (latch_reg & ~clr) | ev; // RQ6 RQ15
	wire [N_FLT-1:0] mask_next  = wr_mask ? mask_new : mask_reg;
	wire irq_n_next = ~|(latch_next & ~mask_next); // RQ16 RQ18
	wire [N_RAIL-1:0] eff_ovuv =
		eff[2*N_RAIL-1:N_RAIL] | eff[N_FLT-1:2*N_RAIL];
	wire [N_FLT-1:0] kill  = eff & ~keep_reg; // RQ22
	wire [N_RAIL-1:0] kill_rail =
		kill[N_RAIL-1:0] | kill[2*N_RAIL-1:N_RAIL] | kill[N_FLT-1:2*N_RAIL];

	// *************************************************************
	// fault counter and fault window timer
	// *************************************************************
	wire        any_ev   = |eff_ev;
	wire        cnt_full = (lim_reg != 4'h0) & (cnt_reg == lim_reg);
	wire        cnt_inc  = any_ev & (cnt_reg != lim_reg); // RQ21
	wire        cnt_trip = any_ev & cnt_full; // RQ21
	wire [11:0] win_ms   = window_ms(tmr_code_reg); // RQ1 RQ2
	wire        tmr_on   = (|eff) & (win_ms != 12'h000); // RQ20
	wire        ms_tick  = (ms_pre_reg == 14'(MS_CYCLES - 1));
	wire        tmr_exp  = tmr_on & ms_tick & (ms_cnt_reg + 12'h001 >= win_ms);

	// *************************************************************
	// power-up gating
	// *************************************************************
	wire rails_ok  = &(i_internal_regulation_ok | ~en) & ~|eff_ovuv;
	wire slot_ok   = i_reset_slot_ready & (|en); // RQ14
	wire hold_done = (hold_cnt_reg == 15'(HOLD_CYCLES - 1));
	wire rel_next  = (state_next == ST_RUN);
	wire pg_next   = i_otp_pg_mode
		? (state_reg == ST_RUN) & rails_ok // RQ19
		: pgval_reg; // RQ14

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_WAIT: begin
				if (slot_ok)
					state_next = ST_CHECK;
			end
			ST_CHECK: begin
				if (!i_otp_regulation_gate_sel || rails_ok) // RQ7 RQ8 RQ9
					state_next = ST_RUN;
				else
					state_next = ST_HOLD; // RQ10
			end
			ST_HOLD: begin
				if (rails_ok)
					state_next = ST_RUN; // RQ10
				else if (hold_done)
					state_next = ST_ABORT; // RQ11
			end
			ST_RUN:   state_next = ST_RUN; // RQ13
			ST_ABORT: state_next = ST_ABORT;
		endcase
	end

	wire [N_RAIL-1:0] off_next = (state_next == ST_ABORT)
		? (en | off_reg) : kill_rail; // RQ11 RQ22
	wire [31:0] sense_word = {20'h0, raw}; // RQ17
	wire [31:0] status_word = {23'h0, pdn_reg, rel_reg,
		state_reg == ST_ABORT, state_reg == ST_HOLD, tmr_on, cnt_reg};
	wire [31:0] rd_mux =
		(i_avs.address == A_CTRL)   ? ctrl_word :
		(i_avs.address == A_IGNORE) ? {20'h0, ign_reg} :
		(i_avs.address == A_KEEP)   ? {20'h0, keep_reg} :
		(i_avs.address == A_LATCH)  ? {20'h0, latch_reg} : // RQ15
		(i_avs.address == A_MASK)   ? {20'h0, mask_reg} :
		(i_avs.address == A_SENSE)  ? sense_word :
		(i_avs.address == A_STATUS) ? status_word : 32'h0;

	// *************************************************************
	// state
	// *************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ack_reg   <= 1'b0;
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg   <= ack_next;
			wait_reg  <= ~ack_next;
			rdata_reg <= ack_next & i_avs.read ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tmr_code_reg <= i_otp_timer_fault;
			lim_reg      <= i_otp_fault_count_limit;
			pgval_reg    <= 1'b0;
			ign_reg      <= i_otp_ignore; // RQ4 RQ3
			keep_reg     <= KEEP_RST;
			mask_reg     <= MASK_RST;
		end else begin
			if (wr_ctrl) begin
				tmr_code_reg <= ctrl_new[F_TMR_LO +: 4]; // RQ2
				lim_reg      <= ctrl_new[F_LIM_LO +: 4];
				pgval_reg    <= ctrl_new[F_PGVAL];
			end
			if (wr_ign)
				ign_reg <= ign_new; // RQ3
			if (wr_keep)
				keep_reg <= keep_new;
			mask_reg <= mask_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			latch_reg      <= '0;
			armed_prev_reg <= '0;
			eff_prev_reg   <= '0;
			cnt_reg        <= 4'h0;
			ms_pre_reg     <= 14'h0;
			ms_cnt_reg     <= 12'h0;
			pdn_reg        <= 1'b0;
		end else begin
			latch_reg      <= latch_next;
			armed_prev_reg <= armed;
			eff_prev_reg   <= eff;
			if (cnt_inc)
				cnt_reg <= cnt_reg + 4'h1;
			else if (wr_status)
				cnt_reg <= wd[F_CNT_LO +: 4];
			ms_pre_reg <= (!tmr_on || ms_tick) ? 14'h0 : ms_pre_reg + 14'h1;
			ms_cnt_reg <= !tmr_on ? 12'h0 : ms_cnt_reg + {11'h0, ms_tick};
			if (tmr_exp || cnt_trip)
				pdn_reg <= 1'b1; // RQ20 RQ21
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_reg      <= ST_WAIT;
			rel_reg        <= 1'b0;
			blank_cnt_reg  <= 14'h0;
			blank_done_reg <= 1'b0;
			hold_cnt_reg   <= 15'h0;
			irq_n_reg      <= 1'b1;
			pg_reg         <= 1'b0;
			rst_n_reg      <= 1'b0;
			pause_reg      <= 1'b0;
			off_reg        <= '0;
		end else begin
			state_reg <= state_next;
			rel_reg   <= rel_next;
			if (rel_reg && !blank_done_reg)
				blank_cnt_reg <= blank_cnt_reg + 14'h1;
			blank_done_reg <= rel_reg &
				(blank_cnt_reg >= 14'(BLANK_CYCLES - 1)); // RQ7
			hold_cnt_reg <= (state_reg == ST_HOLD) ? hold_cnt_reg + 15'h1
				: 15'h0;
			irq_n_reg <= irq_n_next;
			pg_reg    <= pg_next;
			rst_n_reg <= rel_next; // RQ8 RQ10
			pause_reg <= (state_next == ST_HOLD); // RQ10
			off_reg   <= off_next;
		end
	end

	assign o_avs_readdata     = rdata_reg;
	assign o_avs_waitrequest  = wait_reg;
	assign o_host_reset_out_n = rst_n_reg;
	assign o_irq_n_out        = irq_n_reg;
	assign o_power_good_pin   = pg_reg;
	assign o_rail_off         = off_reg;
	assign o_seq_pause        = pause_reg;
	assign o_powerdown_req    = pdn_reg;

	// *************************************************************
	// assertions
	// *************************************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	window_len_a: assert property ( // RQ1
		tmr_exp |-> (ms_cnt_reg + 12'h001 == window_ms(tmr_code_reg)))
		else $error("fault window expired at wrong length");
	window_off_a: assert property ( // RQ2
		(tmr_code_reg == TMR_CODE_OFF) |-> !tmr_on)
		else $error("disabled fault window is running");
	ignored_count_a: assert property ( // RQ5
		(~|eff_ev && !$past(wr_status)) |=> $stable(cnt_reg) ||
		$past(wr_status))
		else $error("fault counter moved without a counted fault");
	ignored_latch_a: assert property ( // RQ6
		(|(ev & ign_reg)) |=> |(latch_reg & $past(ev & ign_reg)))
		else $error("ignored fault did not set its latch");
	latch_clear_a: assert property ( // RQ15
		(|($past(latch_reg) & ~latch_reg)) |-> $past(wr_latch))
		else $error("latch cleared without a host write");
	irq_pin_a: assert property ( // RQ18
		o_irq_n_out == ~|(latch_reg & ~mask_reg))
		else $error("interrupt pin disagrees with unmasked latches");
	hold_reset_a: assert property ( // RQ10
		(state_reg == ST_HOLD) |=> !o_host_reset_out_n || rails_ok ||
		$past(rails_ok))
		else $error("host reset released during recovery hold");
	hold_abort_a: assert property ( // RQ11
		(state_reg == ST_HOLD && hold_done && !rails_ok) |=>
		(state_reg == ST_ABORT) ##1 (o_rail_off == (o_rail_off | $past(en))))
		else $error("recovery window expiry did not abort");
	gate_release_a: assert property ( // RQ8
		(state_reg == ST_CHECK && i_otp_regulation_gate_sel && !rails_ok)
		|=> !rel_reg)
		else $error("reset released with rails out of regulation");
	count_cap_a: assert property ( // RQ21
		(lim_reg != 4'h0 && cnt_reg == lim_reg && any_ev) |=> pdn_reg)
		else $error("fault limit reached without power-down");

	cov_release_c: cover property (state_reg == ST_HOLD ##1
		state_reg == ST_RUN);
	cov_abort_c: cover property (state_reg == ST_ABORT);
	cov_irq_c: cover property (!o_irq_n_out ##[1:20] o_irq_n_out);
	cov_expire_c: cover property (tmr_exp);
endmodule : rsf_supervisor
`default_nettype wire

// ===== testbench/rsf_seq_model.sv
/*
 * rsf_seq_model: stand-in for the rail sequencer and power stage.
 * Assumes one clock shared with the supervisor.
 */
`timescale 1ns/1ps
`default_nettype none
module rsf_seq_model import rsf_pkg::*; (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_start,
	input  wire logic              i_pause,
	input  wire logic [N_RAIL-1:0] i_bad,
	input  wire logic [N_RAIL-1:0] i_rail_off,
	output logic [N_RAIL-1:0]      o_rail_enabled,
	output logic [N_RAIL-1:0]      o_regulation_ok,
	output logic                   o_slot_ready
);
	logic [2:0]        step_reg;
	logic [N_RAIL-1:0] on_reg;
	logic [N_RAIL-1:0] off_reg;
	// one rail every 8 cycles; a rail turned off stays off until reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_start) begin
			step_reg <= 3'h0;
			on_reg   <= '0;
			off_reg  <= '0;
		end else begin
			off_reg <= off_reg | i_rail_off;
			if (!i_pause) begin
				step_reg <= step_reg + 3'h1;
				if (step_reg == 3'h7)
					on_reg <= {on_reg[N_RAIL-2:0], 1'b1};
			end
		end
	end
	assign o_rail_enabled  = on_reg & ~off_reg;
	assign o_regulation_ok = o_rail_enabled & ~i_bad;
	assign o_slot_ready    = on_reg[0];
endmodule : rsf_seq_model
`default_nettype wire

// ===== testbench/test_rsf_supervisor.sv
/*
 * test_rsf_supervisor: self-checking bench for rsf_supervisor.
 * Assumes the shortened sim timing 10/40/4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module test_rsf_supervisor import rsf_pkg::*;;
	localparam int MS = 10;
	localparam int HOLD = 40;
	localparam int BLANK = 4;
	logic i_clk, i_rst_n, start, gate, pgm, rst_out_n, irq_n, pg, pause;
	logic pdn, wreq, slot;
	logic [31:0] rdata;
	logic [3:0] bad, otp_tmr, otp_lim, rail_off, rail_en, reg_ok;
	rsf_avs_req_t avs;
	rsf_flt_t fault, otp_ign;
	int err_total, check_count;
	rsf_supervisor #(.MS_CYCLES(MS), .HOLD_CYCLES(HOLD),
		.BLANK_CYCLES(BLANK)) rsf_supervisor_inst (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(avs),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_fault_raw(fault), .i_internal_regulation_ok(reg_ok),
		.i_rail_enabled(rail_en), .i_reset_slot_ready(slot),
		.i_otp_ignore(otp_ign), .i_otp_timer_fault(otp_tmr),
		.i_otp_fault_count_limit(otp_lim),
		.i_otp_regulation_gate_sel(gate), .i_otp_pg_mode(pgm),
		.o_host_reset_out_n(rst_out_n), .o_irq_n_out(irq_n),
		.o_power_good_pin(pg), .o_rail_off(rail_off),
		.o_seq_pause(pause), .o_powerdown_req(pdn));
	rsf_seq_model rsf_seq_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_start(start), .i_pause(pause), .i_bad(bad),
		.i_rail_off(rail_off), .o_rail_enabled(rail_en),
		.o_regulation_ok(reg_ok), .o_slot_ready(slot));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// ************************************************
	// shared tasks
	// ************************************************
	task automatic finish_test();
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	task automatic bus(input logic w, input logic [4:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_clk);
		avs <= '{a, !w, w, 4'hF, d};
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdata;
		avs <= '0;
		if (n >= 20) begin
			err_total++;
			$display("ERROR %0t bus answer missing", $time);
			finish_test();
		end
	endtask : bus
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	function automatic logic hit(input int s);
		case (s)
			0: return rst_out_n === 1'b1;
			1: return pause === 1'b1;
			2: return rail_off !== 4'h0;
			3: return pdn === 1'b1;
			default: return rail_en === 4'hF;
		endcase
	endfunction : hit
	task automatic wait_on(input int s, input int lim, output int n);
		n = 0;
		while (!hit(s) && n < lim) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= lim) begin
			err_total++;
			$display("ERROR %0t wait %0d ran out", $time, s);
			finish_test();
		end
	endtask : wait_on
	task automatic power_up(input logic g, input logic [3:0] b,
			input logic [11:0] ign, input logic [3:0] t, input logic [3:0] l);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		start <= 1'b0;
		fault <= '0;
		gate <= g;
		bad <= b;
		otp_ign <= ign;
		otp_tmr <= t;
		otp_lim <= l;
		tick(5);
		i_rst_n <= 1'b1;
		start <= 1'b1;
	endtask : power_up
	task automatic up_good(input logic [11:0] ign, input logic [3:0] t,
			input logic [3:0] l);
		int n;
		power_up(1'b1, 4'h0, ign, t, l);
		wait_on(4, 100, n);
		tick(BLANK + 4);
	endtask : up_good
	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset();
		logic [31:0] q;
		int n;
		power_up(1'b1, 4'h0, 12'hA5C, 4'h3, 4'h2);
		chk(rst_out_n, 1'b0);
		chk(irq_n, 1'b1);
		rd(A_IGNORE, 32'hA5C);
		rd(A_KEEP, 32'h0);
		rd(A_MASK, 32'h0);
		bus(1'b0, A_CTRL, 32'h0, q);
		chk(q & 32'hFF, 32'h23);
		rd(5'h1C, 32'h0);
		wait_on(0, 200, n);
		tick(3);
		chk(pg, 1'b1);
	endtask : t_reset
	task automatic t_free();
		int n;
		pgm <= 1'b0;
		power_up(1'b0, 4'hF, 12'h0, 4'hF, 4'h0);
		fault.ov[0] <= 1'b1;
		wait_on(0, 200, n);
		chk(pause, 1'b0);
		rd(A_LATCH, 32'h0);
		chk(pg, 1'b0);
		wr(A_CTRL, 32'h10F);
		tick(2);
		chk(pg, 1'b1);
		rd(A_LATCH, 32'h10);
		pgm <= 1'b1;
	endtask : t_free
	task automatic t_hold();
		int n;
		power_up(1'b1, 4'h1, 12'h0, 4'hF, 4'h0);
		wait_on(1, 200, n);
		chk(rst_out_n, 1'b0);
		tick(HOLD / 2);
		chk(rail_en, 4'h1);
		bad <= 4'h0;
		wait_on(0, HOLD, n);
		tick(30);
		chk(rail_en, 4'hF);
	endtask : t_hold
	task automatic t_abort();
		int n;
		power_up(1'b1, 4'h1, 12'h0, 4'hF, 4'h0);
		wait_on(1, 200, n);
		wait_on(2, HOLD + 20, n);
		chk(n >= HOLD - 3, 1'b1);
		chk(rail_off, 4'h1);
		chk(rst_out_n, 1'b0);
	endtask : t_abort
	task automatic t_irq();
		logic [31:0] q;
		int n;
		up_good(12'h0, 4'hF, 4'h0);
		fault.ilim[1] <= 1'b1;
		wait_on(2, 10, n);
		chk(rail_off, 4'h2);
		tick(3);
		rd(A_LATCH, 32'h2);
		chk(irq_n, 1'b0);
		rd(A_SENSE, 32'h2);
		bus(1'b0, A_STATUS, 32'h0, q);
		chk(q & 32'h10F, 32'h0);
		fault.ilim[1] <= 1'b0;
		tick(3);
		rd(A_SENSE, 32'h0);
		wr(A_LATCH, 32'h0);
		rd(A_LATCH, 32'h2);
		wr(A_MASK, 32'h2);
		tick(3);
		chk(irq_n, 1'b1);
		wr(A_MASK, 32'h0);
		tick(3);
		chk(irq_n, 1'b0);
		wr(A_LATCH, 32'h2);
		tick(3);
		rd(A_LATCH, 32'h0);
		chk(irq_n, 1'b1);
	endtask : t_irq
	task automatic t_ignore();
		logic [31:0] q;
		up_good(12'h002, 4'h0, 4'h1);
		fault.ilim[1] <= 1'b1;
		tick(3 * MS);
		chk(pdn, 1'b0);
		chk(rail_off, 4'h0);
		rd(A_LATCH, 32'h2);
		chk(irq_n, 1'b0);
		bus(1'b0, A_STATUS, 32'h0, q);
		chk(q & 32'hF, 32'h0);
	endtask : t_ignore
	task automatic t_timer();
		int n;
		up_good(12'h0, 4'h2, 4'h0);
		wr(A_KEEP, 32'h2);
		fault.ilim[1] <= 1'b1;
		tick(2 * MS);
		fault.ilim[1] <= 1'b0;
		tick(6 * MS);
		chk(pdn, 1'b0);
		fault.ilim[1] <= 1'b1;
		wait_on(3, 6 * MS, n);
		chk(n >= 3 * MS && n <= 4 * MS + 5, 1'b1);
		chk(rail_off, 4'h0);
	endtask : t_timer
	task automatic t_count();
		logic [31:0] q;
		up_good(12'h0, 4'hF, 4'h2);
		wr(A_KEEP, 32'hFFF);
		for (int i = 0; i < 3; i++) begin
			fault.ilim[2] <= 1'b1;
			tick(3);
			fault.ilim[2] <= 1'b0;
			tick(3);
			if (i == 0)
				chk(pdn, 1'b0);
		end
		bus(1'b0, A_STATUS, 32'h0, q);
		chk(q & 32'h10F, 32'h102);
	endtask : t_count
	initial begin
		err_total = 0;
		check_count = 0;
		i_rst_n = 1'b0;
		start = 1'b0;
		avs = '0;
		fault = '0;
		otp_ign = '0;
		otp_tmr = 4'hF;
		otp_lim = 4'h0;
		gate = 1'b1;
		pgm = 1'b1;
		bad = 4'h0;
		t_reset();
		t_free();
		t_hold();
		t_abort();
		t_irq();
		t_ignore();
		t_timer();
		t_count();
		finish_test();
	end
endmodule : test_rsf_supervisor
`default_nettype wire
